// ---- design/rsc_roof_control_unit.sv ----
// Roof control unit: serial command decode, switch handling, motor commands.
// Assumes AXI4-Lite master on aclk, asynchronous pins, 200 MHz clock.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rsc_roof_control_unit #(
   parameter int BIT_CYC = rsc_pkg::BIT_CYCLES,
   parameter int SLOT_CYC = rsc_pkg::SLOT_CYCLES,
   parameter int LONG_CYC = rsc_pkg::LONG_PRESS_CYCLES
) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write address and data
   input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [rsc_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [rsc_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Link from central computer
   input wire logic serial_line,
   input wire logic window_authorisation_input,
   input wire logic battery_ok_input,
   // Roof console and dashboard switches
   input wire logic sunroof_open_sw,
   input wire logic sunroof_close_sw,
   input wire logic open_air_open_sw,
   input wire logic open_air_close_sw,
   input wire logic blind_open_sw,
   input wire logic blind_close_sw,
   input wire logic rear_down_sw,
   input wire logic rear_up_sw,
   input wire logic rear_inhibit_sw,
   // End of travel
   input wire logic rear_down_end,
   input wire logic blind_open_end,
   input wire logic sunroof_open_end,
   // Motor commands
   output logic sunroof_open,
   output logic sunroof_close,
   output logic blind_open,
   output logic blind_close,
   output logic rear_up,
   output logic rear_down,
   output logic front_up,
   output logic front_down
);
   import rsc_pkg::*;
   localparam int HOLD_CYC = HOLD_BITS * BIT_CYC;
   localparam int HW = $clog2(HOLD_CYC + 1);
   localparam int LW = $clog2(LONG_CYC + 1);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      // Registers
      logic ctrl_en;
      logic ctrl_ser;
      logic err_par;
      logic err_idle;
      logic [FRAME_CNT_W-1:0] frames;
      logic [DATA_BITS-1:0] last_cmd;
      // Bus slave
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [DATA_W-1:0] rdata;
      logic have_aw;
      logic have_w;
      logic [ADDR_W-1:0] aw_addr;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      // Command control
      logic [1:0] scmd;
      logic [HW-1:0] hold;
      logic [LW-1:0] long_cnt;
      logic rear_ot;
      logic blind_ot;
      logic roof_ot;
      // Motor outputs
      logic [7:0] mot;
   } rsc_top_s;

   rsc_top_s q, next_q;
   rsc_pins_s pins;
   logic [$bits(rsc_pins_s)-1:0] pins_sync;
   rsc_frame_if frm ();

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Address decode shared by read and write paths
   function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
      return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_ERR) || (a == REG_FRAMES);
   endfunction

   // Byte-lane merge for partial writes
   function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] new_v,
                                                    input logic [3:0] strb);
      logic [DATA_W-1:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
      end
      return r;
   endfunction

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   rsc_pin_sync #(
      .W($bits(rsc_pins_s)),
      .RESET_VAL(PINS_RESET)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .pin_in({serial_line, window_authorisation_input, battery_ok_input, sunroof_open_sw,
               sunroof_close_sw, open_air_open_sw, open_air_close_sw, blind_open_sw,
               blind_close_sw, rear_down_sw, rear_up_sw, rear_inhibit_sw, rear_down_end,
               blind_open_end, sunroof_open_end}),
      .pin_out(pins_sync)
   );
   assign pins = rsc_pins_s'(pins_sync);

   rsc_frame_rx #(
      .BIT_CYC(BIT_CYC),
      .SLOT_CYC(SLOT_CYC)
   ) u_rx (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .line(pins.serial_line),
      .rx_en(q.ctrl_ser),
      .frm(frm)
   );

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   logic permit;
   logic rear_ok;
   logic s_act;
   logic s_close;
   logic oa_long;
   logic roof_close_req;
   logic up_front;
   logic up_rear;
   logic close_blind;
   logic [DATA_W-1:0] ctrl_word;
   logic [DATA_W-1:0] wr_word;
   logic err_clr_par;
   logic err_clr_idle;

   always_comb begin
      next_q = q;
      err_clr_par = 1'b0;
      err_clr_idle = 1'b0;
      ctrl_word = '0;
      ctrl_word[CTRL_EN_POS] = q.ctrl_en;
      ctrl_word[CTRL_SER_POS] = q.ctrl_ser;
      wr_word = lane_merge('0, q.wdata, q.wstrb);
      // Permission first, as the status read below reports it
      permit = q.ctrl_en & pins.auth & pins.batt_ok;
      rear_ok = permit & ~pins.rear_inhibit_sw;

      // Bus write: address and data taken in either order
      if (s_axi_awvalid && q.awready) begin
         next_q.have_aw = 1'b1;
         next_q.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         next_q.have_w = 1'b1;
         next_q.wdata = s_axi_wdata;
         next_q.wstrb = s_axi_wstrb;
      end
      if (q.have_aw && q.have_w && !q.bvalid) begin
         next_q.have_aw = 1'b0;
         next_q.have_w = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp = reg_mapped(q.aw_addr) ? RESP_OKAY : RESP_DECERR;
         if (q.aw_addr == REG_CTRL) begin
            ctrl_word = lane_merge(ctrl_word, q.wdata, q.wstrb);
            next_q.ctrl_en = ctrl_word[CTRL_EN_POS];
            next_q.ctrl_ser = ctrl_word[CTRL_SER_POS];
         end
         if (q.aw_addr == REG_ERR) begin
            err_clr_par = wr_word[ERR_PAR_POS];
            err_clr_idle = wr_word[ERR_IDLE_POS];
         end
      end else if (q.bvalid && s_axi_bready) begin
         next_q.bvalid = 1'b0;
      end

      // Bus read: data answered the cycle after the address is taken
      if (s_axi_arvalid && q.arready) begin
         next_q.rvalid = 1'b1;
         next_q.rresp = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
         next_q.rdata = '0;
         unique case (s_axi_araddr)
            REG_CTRL: next_q.rdata = ctrl_word;
            REG_STATUS: begin
               next_q.rdata[ST_AUTH_POS] = pins.auth;
               next_q.rdata[ST_BATT_POS] = pins.batt_ok;
               next_q.rdata[ST_PERMIT_POS] = permit;
               next_q.rdata[ST_CMD_LSB +: DATA_BITS] = q.last_cmd;
               next_q.rdata[ST_OUT_LSB +: 8] = q.mot;
            end
            REG_ERR: begin
               next_q.rdata[ERR_PAR_POS] = q.err_par;
               next_q.rdata[ERR_IDLE_POS] = q.err_idle;
            end
            REG_FRAMES: next_q.rdata[FRAME_CNT_W-1:0] = q.frames;
            default: next_q.rdata = '0;
         endcase
      end else if (q.rvalid && s_axi_rready) begin
         next_q.rvalid = 1'b0;
      end
      next_q.awready = !next_q.have_aw && !next_q.bvalid;
      next_q.wready = !next_q.have_w && !next_q.bvalid;
      next_q.arready = !next_q.rvalid;

      // Receive errors are sticky; a new error beats a clear in the same cycle
      next_q.err_par = (q.err_par & ~err_clr_par) | frm.parity_err;
      next_q.err_idle = (q.err_idle & ~err_clr_idle) | frm.idle_err;

      // Serial commands stay active for a hold window, renewed by each frame whose ADJ_POS bit is ADJ_MODE
      if (frm.valid) begin
         next_q.frames = q.frames + 1'b1;
         next_q.last_cmd = frm.payload;
         // Reserved bit is not looked at
         if (frm.payload[ADJ_POS] == ADJ_MODE) begin
            next_q.scmd = frm.payload[ACT_MSB:ACT_LSB];
            next_q.hold = HW'(HOLD_CYC);
         end
      end else if (q.hold != '0) begin
         next_q.hold = q.hold - 1'b1;
      end
      s_act = (q.hold != '0) & permit;
      s_close = s_act & (q.scmd == ACT_CLOSE_ALL);

      // Open air close only counts after a sustained press
      if (pins.open_air_close_sw && permit) begin
         if (q.long_cnt != LW'(LONG_CYC)) next_q.long_cnt = q.long_cnt + 1'b1;
      end else begin
         next_q.long_cnt = '0;
      end
      oa_long = (q.long_cnt == LW'(LONG_CYC));

      // Closing is level driven: it stops as soon as the request goes away
      roof_close_req = pins.sunroof_close_sw | oa_long | s_close;
      up_front = oa_long | s_close;
      up_rear = pins.rear_up_sw | oa_long | s_close;
      close_blind = pins.blind_close_sw | s_close;

      // One-touch latches for downward and opening moves only
      if (!rear_ok || up_rear || pins.rear_down_end) begin
         next_q.rear_ot = 1'b0;
      end else if (pins.rear_down_sw || pins.open_air_open_sw ||
                   (s_act && q.scmd == ACT_OPEN_REAR)) begin
         next_q.rear_ot = 1'b1;
      end
      if (!permit || close_blind || pins.blind_open_end) begin
         next_q.blind_ot = 1'b0;
      end else if (pins.blind_open_sw || (s_act && q.scmd == ACT_OPEN_ROOF)) begin
         next_q.blind_ot = 1'b1;
      end
      if (!permit || roof_close_req || pins.sunroof_open_end) begin
         next_q.roof_ot = 1'b0;
      end else if (s_act && q.scmd == ACT_OPEN_ROOF) begin
         next_q.roof_ot = 1'b1;
      end

      // Motor commands; a close request always masks the opposite move
      next_q.mot = '0;
      if (permit) begin
         next_q.mot[0] = (pins.sunroof_open_sw | pins.open_air_open_sw | q.roof_ot) &
                         ~roof_close_req & ~pins.sunroof_open_end;
         next_q.mot[1] = roof_close_req;
         next_q.mot[2] = q.blind_ot & ~close_blind & ~pins.blind_open_end;
         next_q.mot[3] = close_blind;
         next_q.mot[4] = up_rear & rear_ok;
         next_q.mot[5] = q.rear_ot & rear_ok & ~up_rear & ~pins.rear_down_end;
         next_q.mot[6] = up_front;
         next_q.mot[7] = (pins.open_air_open_sw | (s_act && q.scmd == ACT_OPEN_FRONT)) &
                         ~up_front;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.ctrl_en <= CTRL_EN_RST;
         q.ctrl_ser <= CTRL_SER_RST;
      end else if (ce) begin
         q <= next_q;
      end
   end

   // ----------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rdata = q.rdata;
   assign sunroof_open = q.mot[0];
   assign sunroof_close = q.mot[1];
   assign blind_open = q.mot[2];
   assign blind_close = q.mot[3];
   assign rear_up = q.mot[4];
   assign rear_down = q.mot[5];
   assign front_up = q.mot[6];
   assign front_down = q.mot[7];
endmodule // rsc_roof_control_unit
`default_nettype wire

// ---- include/rsc_pkg.sv ----
// Constants, register map and pin bundle for the roof control unit.
// Assumes a 200 MHz system clock; the bit, slot and long-press cycle counts are derived here.
package rsc_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int BIT_TIME_US = 4100;
   localparam int SLOT_TIME_US = 2600;
   localparam int BIT_CYCLES = BIT_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int SLOT_CYCLES = SLOT_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int IDLE_BITS = 5;
   localparam int HOLD_BITS = 12;
   localparam int LONG_PRESS_MS = 500;
   localparam int LONG_PRESS_CYCLES = LONG_PRESS_MS * 1000000 / CLK_PERIOD_NS;

   // ----------------------------------------
   // Frame layout and action codes
   // ----------------------------------------
   localparam int DATA_BITS = 4;
   localparam int FRAME_BITS = DATA_BITS + 1;
   localparam int ADJ_POS = 0;
   localparam int ACT_LSB = 2;
   localparam int ACT_MSB = 3;
   localparam logic ADJ_MODE = 1'b0;
   localparam logic [1:0] ACT_OPEN_ROOF = 2'h0;
   localparam logic [1:0] ACT_OPEN_FRONT = 2'h1;
   localparam logic [1:0] ACT_OPEN_REAR = 2'h2;
   localparam logic [1:0] ACT_CLOSE_ALL = 2'h3;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] REG_ERR = 4'h8;
   localparam logic [ADDR_W-1:0] REG_FRAMES = 4'hC;
   localparam int CTRL_EN_POS = 0;
   localparam int CTRL_SER_POS = 1;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic CTRL_SER_RST = 1'b1;
   localparam int ERR_PAR_POS = 0;
   localparam int ERR_IDLE_POS = 1;
   localparam int ST_AUTH_POS = 0;
   localparam int ST_BATT_POS = 1;
   localparam int ST_PERMIT_POS = 2;
   localparam int ST_CMD_LSB = 4;
   localparam int ST_OUT_LSB = 8;
   localparam int FRAME_CNT_W = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ----------------------------------------
   // Pins crossing into the clock domain
   // ----------------------------------------
   typedef struct packed {
      logic serial_line;
      logic auth;
      logic batt_ok;
      logic sunroof_open_sw;
      logic sunroof_close_sw;
      logic open_air_open_sw;
      logic open_air_close_sw;
      logic blind_open_sw;
      logic blind_close_sw;
      logic rear_down_sw;
      logic rear_up_sw;
      logic rear_inhibit_sw;
      logic rear_down_end;
      logic blind_open_end;
      logic sunroof_open_end;
   } rsc_pins_s;
   localparam rsc_pins_s PINS_RESET = 15'h4000; // Serial line idles high

endpackage

// ---- include/rsc_frame_if.sv ----
// Carries decoded frames from the serial receiver to the control core.
// Single clock domain; all signals are one-cycle pulses except payload.
`timescale 1ns/1ps
`default_nettype none
interface rsc_frame_if;
   logic valid;
   logic [rsc_pkg::DATA_BITS-1:0] payload;
   logic parity_err;
   logic idle_err;
   modport rx (output valid, output payload, output parity_err, output idle_err);
   modport ctl (input valid, input payload, input parity_err, input idle_err);
endinterface
`default_nettype wire

// ---- design/rsc_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes every bit is a slow level; output moves when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Pins
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } rsc_sync_s;

   rsc_sync_s q, next_q;

   // Stage one only feeds stage two, so no logic sees a metastable value
   always_comb begin
      next_q = q;
      next_q.s1 = pin_in;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      for (int i = 0; i < W; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            next_q.q[i] = q.s3[i];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
      end else if (ce) begin
         q <= next_q;
      end
   end

   assign pin_out = q.q;
endmodule // rsc_pin_sync
`default_nettype wire

// ---- design/rsc_frame_rx.sv ----
// Serial frame receiver: start bit, four data bits, even parity, idle check.
// Assumes line is already synchronised to aclk and idles high.
`timescale 1ns/1ps
`default_nettype none
module rsc_frame_rx #(
   parameter int BIT_CYC = rsc_pkg::BIT_CYCLES,
   parameter int SLOT_CYC = rsc_pkg::SLOT_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // Line and control
   input wire logic line,
   input wire logic rx_en,
   // Decoded frames
   rsc_frame_if.rx frm
);
   import rsc_pkg::*;
   localparam int IDLE_CYC = IDLE_BITS * BIT_CYC;
   localparam int CW = $clog2(IDLE_CYC + 1);

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rsc_rx_e;
   typedef struct packed {
      rsc_rx_e st;
      logic [CW-1:0] cnt;
      logic [CW-1:0] idle_cnt;
      logic [2:0] bitn;
      logic [FRAME_BITS-1:0] sh;
      logic prev;
      logic idle_ok;
      logic valid;
      logic perr;
      logic ierr;
   } rsc_rx_s;

   rsc_rx_s q, next_q;
   logic [FRAME_BITS-1:0] word;

   // Frame sequencing; bits sampled mid-period, LSB first
   always_comb begin
      next_q = q;
      next_q.valid = 1'b0;
      next_q.perr = 1'b0;
      next_q.ierr = 1'b0;
      next_q.prev = line;
      word = {line, q.sh[FRAME_BITS-1:1]};
      unique case (q.st)
         RX_IDLE: begin
            if (line) begin
               if (q.idle_cnt != CW'(IDLE_CYC)) next_q.idle_cnt = q.idle_cnt + 1'b1;
            end else if (q.prev && rx_en) begin
               next_q.idle_ok = (q.idle_cnt == CW'(IDLE_CYC));
               next_q.st = RX_START;
               next_q.cnt = '0;
            end
         end
         RX_START: begin
            next_q.cnt = q.cnt + 1'b1;
            // A high inside the first half of the signal slot is a glitch, not a start
            if (line && q.cnt < CW'(SLOT_CYC / 2)) begin
               next_q.st = RX_IDLE;
               next_q.idle_cnt = '0;
            end else if (q.cnt == CW'(BIT_CYC / 2 - 1)) begin
               next_q.cnt = '0;
               next_q.bitn = '0;
               next_q.st = line ? RX_IDLE : RX_BITS;
               next_q.idle_cnt = '0;
            end
         end
         RX_BITS: begin
            next_q.cnt = q.cnt + 1'b1;
            if (q.cnt == CW'(BIT_CYC - 1)) begin
               next_q.cnt = '0;
               next_q.sh = word;
               next_q.bitn = q.bitn + 1'b1;
               if (q.bitn == 3'(FRAME_BITS - 1)) begin
                  next_q.st = RX_IDLE;
                  next_q.idle_cnt = '0;
                  next_q.prev = 1'b0; // Low parity tail is not a new start
                  next_q.perr = ^word;
                  next_q.ierr = ~q.idle_ok;
                  next_q.valid = ~(^word) & q.idle_ok;
               end
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '{st: RX_IDLE, cnt: '0, idle_cnt: '0, bitn: '0, sh: '0, prev: 1'b1,
                idle_ok: 1'b0, valid: 1'b0, perr: 1'b0, ierr: 1'b0};
      end else if (ce) begin
         q <= next_q;
      end
   end

   assign frm.valid = q.valid;
   assign frm.payload = q.sh[DATA_BITS-1:0];
   assign frm.parity_err = q.perr;
   assign frm.idle_err = q.ierr;
endmodule // rsc_frame_rx
`default_nettype wire

// ---- sim/rsc_checker.sv ----
// Assertions on the roof control unit ports, bound to the top module.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rsc_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready, s_axi_arready,
   // Pins and motor commands
   input wire logic window_authorisation_input, battery_ok_input, rear_inhibit_sw, open_air_close_sw,
   input wire logic sunroof_open, blind_open, rear_up, rear_down, front_up, front_down
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // -------------------------------
   // Eight cycles covers synchroniser plus output flop
   // -------------------------------
   sequence s_unauth; !window_authorisation_input [*8]; endsequence
   sequence s_lowbat; !battery_ok_input [*8]; endsequence
   sequence s_inhib; rear_inhibit_sw [*8]; endsequence
   AST_AUTH: assert property (s_unauth |-> !(sunroof_open | blind_open | rear_down | front_down))
      else $error("motion while unauthorised");
   AST_BATT: assert property (s_lowbat |-> !(sunroof_open | blind_open | rear_down | front_down))
      else $error("motion while battery low");
   AST_INHIBIT: assert property (s_inhib |-> !(rear_up | rear_down))
      else $error("rear window moved while inhibited");
   AST_LONG: assert property ($rose(open_air_close_sw) && !front_up |=> !front_up [*8])
      else $error("closing without long press");
   AST_EXCL: assert property (!(rear_up & rear_down) && !(front_up & front_down))
      else $error("up and down together");
   AST_BDONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_RDONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   AST_ARBUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
endmodule // rsc_checker
bind rsc_roof_control_unit rsc_checker u_chk (.*);
`default_nettype wire

// ---- sim/rsc_link_host.sv ----
// Model of the central computer sending command frames on the line.
// Assumes the unit samples on aclk; the line rests high between frames.
`timescale 1ns/1ps
`default_nettype none
module rsc_link_host #(
   parameter int BIT = 40
) (
   // Clock
   input wire logic aclk,
   // Serial line
   output var logic line
);
   initial line = 1'b1;
   // Gap, low start, data LSB first, parity; bad flips the parity
   task automatic send(input logic [3:0] d, input logic bad, input int gap);
      logic [5:0] f;
      f = {(^d) ^ bad, d, 1'b0};
      repeat (gap * BIT) @(posedge aclk);
      for (int i = 0; i < 6; i++) begin
         line <= f[i];
         repeat (BIT) @(posedge aclk);
      end
      line <= 1'b1;
   endtask
endmodule // rsc_link_host
`default_nettype wire

// ---- sim/rsc_roof_control_unit_tb.sv ----
// Self-checking bench for the roof control unit and a frame sender.
// Assumes shortened bit and long-press counts to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module rsc_roof_control_unit_tb;
   import rsc_pkg::*;
   localparam int B = 40;
   logic aclk = '0, aresetn = '0, ce = 1'b1, serial_line;
   logic window_authorisation_input = 1'b1, battery_ok_input = 1'b1;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] sw = '0;
   logic [7:0] mot;
   int fails = 0, checks_done = 0;
   rsc_roof_control_unit #(.BIT_CYC(B), .SLOT_CYC(26), .LONG_CYC(50)) dut (.*, .sunroof_open_sw(sw[11]),
      .sunroof_close_sw(sw[10]), .open_air_open_sw(sw[9]), .open_air_close_sw(sw[8]), .blind_open_sw(sw[7]),
      .blind_close_sw(sw[6]), .rear_down_sw(sw[5]), .rear_up_sw(sw[4]), .rear_inhibit_sw(sw[3]),
      .rear_down_end(sw[2]), .blind_open_end(sw[1]), .sunroof_open_end(sw[0]), .front_down(mot[7]),
      .front_up(mot[6]), .rear_down(mot[5]), .rear_up(mot[4]), .blind_close(mot[3]), .blind_open(mot[2]),
      .sunroof_close(mot[1]), .sunroof_open(mot[0]));
   rsc_link_host #(.BIT(B)) host (.aclk, .line(serial_line));
   always #2.5 aclk = ~aclk;
   task automatic summarize;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // One bus transfer; each channel drops valid at the edge it is taken
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{~w}};
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_bvalid | s_axi_rvalid) begin
            {q, r} = w ? {q, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
            {s_axi_bready, s_axi_rready} <= '0;
            k = 999;
         end
         k++;
      end while (k < 200);
      if (k < 1000) begin
         fails++;
         summarize();
      end
      @(posedge aclk);
   endtask
   // Drive switch and end pins, then judge the motor outputs
   task automatic pins(input logic [11:0] v, input logic [7:0] e);
      sw <= v;
      wt(12);
      cmp("motors", {24'h0, e}, {24'h0, mot});
   endtask
   // -------------------------------
   // Scenarios
   // -------------------------------
   task automatic t_sw;
      battery_ok_input <= 1'b0;
      pins(12'h020, 8'h00);
      battery_ok_input <= 1'b1;
      pins(12'h028, 8'h00);
      pins(12'h020, 8'h20);
      pins(12'h000, 8'h20);
      pins(12'h004, 8'h00);
      pins(12'h010, 8'h10);
      pins(12'h000, 8'h00);
      pins(12'h080, 8'h04);
      pins(12'h000, 8'h04);
      pins(12'h202, 8'hA1);
      pins(12'h004, 8'h00);
      pins(12'h100, 8'h00);
      wt(60);
      pins(12'h100, 8'h52);
      pins(12'h000, 8'h00);
   endtask
   // Reserved bit set on purpose; auth stays low until the hold window is over,
   // otherwise the still-running command would latch the openings again
   task automatic t_codes;
      logic [7:0] e [4];
      e = '{8'h05, 8'h80, 8'h20, 8'h5A};
      for (int c = 0; c < 4; c++) begin
         host.send({c[1:0], 2'b10}, 1'b0, 6);
         wt(3 * B);
         cmp("frame", {24'h0, e[c]}, {24'h0, mot});
         window_authorisation_input <= 1'b0;
         wt(12);
         cmp("unauth", '0, {24'h0, mot});
         wt(13 * B);
         window_authorisation_input <= 1'b1;
      end
   endtask
   task automatic t_link;
      host.send(4'h5, 1'b0, 6);
      wt(3 * B);
      cmp("select", '0, {24'h0, mot});
      host.send(4'h4, 1'b1, 6);
      wt(3 * B);
      cmp("parity", '0, {24'h0, mot});
      host.send(4'h4, 1'b0, 1);
      wt(3 * B);
      cmp("idle", '0, {24'h0, mot});
      xfer(1'b0, REG_ERR, '0);
      cmp("errors", 32'h3, q);
      xfer(1'b1, REG_ERR, 32'h3);
      cmp("wresp", '0, {30'h0, r});
      xfer(1'b0, REG_ERR, '0);
      cmp("cleared", '0, q);
      xfer(1'b0, REG_FRAMES, '0);
      cmp("frames", 32'h5, q);
      xfer(1'b0, 4'h2, '0);
      cmp("unmapped", 32'h3, {30'h0, r});
   endtask
   initial begin
      wt(20);
      aresetn <= 1'b1;
      wt(3);
      xfer(1'b0, REG_CTRL, '0);
      cmp("ctrl", 32'h3, q);
      t_sw();
      t_codes();
      t_link();
      summarize();
   end
endmodule // rsc_roof_control_unit_tb
`default_nettype wire
